/* common/rtc_pkg.sv */
// constants for the clock latch and interrupt block
// assumes an 8-bit bus with a 5-bit address and eight time fields
package rtc_pkg;
  localparam int DW            = 8;
  localparam int AW            = 5;
  localparam int NUM_FIELDS    = 8;
  localparam int FIELD_AW      = 3;
  localparam int NUM_TICKS     = 6;
  localparam int SYNC_STAGES   = 3;

  localparam logic [AW-1:0] ADDR_HUND        = 5'h00;
  localparam logic [AW-1:0] ADDR_TIME_LAST   = 5'h07;
  localparam logic [AW-1:0] ADDR_ALARM_FIRST = 5'h08;
  localparam logic [AW-1:0] ADDR_ALARM_LAST  = 5'h0f;
  localparam logic [AW-1:0] ADDR_STATUS      = 5'h10;
  localparam logic [AW-1:0] ADDR_CMD         = 5'h11;

  localparam int ST_ALARM   = 0;
  localparam int ST_TICK_LO = 1;
  localparam int ST_TICK_HI = 6;
  localparam int ST_SUMMARY = 7;
  localparam int CMD_GIE    = 4;
  localparam int CMD_TEST   = 5;
  localparam int FIELD_MASK = 7;
  localparam int SEC_TICK   = 2;

  localparam logic [DW-1:0] MASK_RESET   = 8'h00;
  localparam logic [DW-1:0] CMD_RESET    = 8'h00;
  localparam logic [DW-1:0] STATUS_RESET = 8'h00;
  localparam logic [DW-1:0] ALARM_RESET  = 8'h00;
  localparam logic [DW-1:0] ZERO_FIELD   = 8'h00;
  localparam logic [DW-1:0] SEC_ONLY     = 8'h08;
  localparam logic [15:0]   BUS_IDLE     = 16'he000;
endpackage

/* common/alarm_mem_if.sv */
// link between the register logic and the alarm storage
// assumes one clock domain; contents feed the comparator every cycle
`timescale 1ns/1ns
`default_nettype none
interface alarm_mem_if;
  logic                                                    we;
  logic [rtc_pkg::FIELD_AW-1:0]                            waddr;
  logic [rtc_pkg::DW-1:0]                                  wdata;
  logic [rtc_pkg::FIELD_AW-1:0]                            raddr;
  logic [rtc_pkg::DW-1:0]                                  rdata;
  logic [rtc_pkg::NUM_FIELDS-1:0][rtc_pkg::DW-1:0]         contents;
  modport ctrl (output we, waddr, wdata, raddr, input rdata, contents);
  modport mem  (input we, waddr, wdata, raddr, output rdata, contents);
endinterface
`default_nettype wire

/* hw/pin_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
// assumes raw comes from outside the ref_clk domain
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int           W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] filt
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } sync_s;
  sync_s q;
  sync_s next_q;

  always_comb begin
    next_q     = q;
    next_q.s1  = raw;
    next_q.s2  = q.s1;
    next_q.s3  = q.s2;
    // s1 is read by s2 only; a bit moves once s2 and s3 agree
    next_q.val = (q.s2 & q.s3) | (q.val & (q.s2 | q.s3));
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      q <= next_q;
    end
  end

  assign filt = q.val;
endmodule
`default_nettype wire

/* hw/alarm_ram.sv */
// alarm storage: one byte per time field, registered read port
// assumes writes and reads come from the register logic on ref_clk
`timescale 1ns/1ns
`default_nettype none
module alarm_ram (
  input  wire logic  ref_clk,
  input  wire logic  resetn,
  alarm_mem_if.mem   port
);
  typedef struct packed {
    logic [rtc_pkg::NUM_FIELDS-1:0][rtc_pkg::DW-1:0] mem;
    logic [rtc_pkg::DW-1:0]                          rdata;
  } ram_s;
  ram_s q;
  ram_s next_q;

  always_comb begin
    next_q       = q;
    next_q.rdata = q.mem[port.raddr];
    if (port.we) begin
      next_q.mem[port.waddr] = port.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{mem: {rtc_pkg::NUM_FIELDS{rtc_pkg::ALARM_RESET}}, rdata: rtc_pkg::ALARM_RESET};
    end else begin
      q <= next_q;
    end
  end

  assign port.rdata    = q.rdata;
  assign port.contents = q.mem;
endmodule
`default_nettype wire

/* hw/rtc_event_core.sv */
// time read latching, event status and interrupt logic of the clock
// assumes the counter chain supplies live values and one-cycle tick pulses
// on ref_clk; bus pins arrive asynchronously and are filtered here
//
// Operation
// - hundredths read captures the seven other counters
// - hundredths read returns live, never latched value
// - held values stay until next hundredths read
// - alarm storage reads return stored bytes directly
// - status flags every counter increment, mask ignored
// - status clears right after it is read
// - top status bit marks any raised interrupt
// - alarm interrupt also sets lowest status bit
// - status read releases the interrupt output
// - periodic needs global enable and mask bit
// - periodic fires on matching counter increment
// - enabling never restarts counters; natural period spacing
// - alarm needs global enable and alarm mask
// - exact match sets alarm, summary, interrupt
// - masked alarm fields other than hundredths are left out
// - masked hundredths field compares as zero
// - software reads status to clear, identify source
// - mask written at status location; command next
// - mask value 08h enables one-second interrupt only
// - test bit clocks hundredths from oscillator
`timescale 1ns/1ns
`default_nettype none
module rtc_event_core (
  input  wire logic                                            ref_clk,
  input  wire logic                                            resetn,
  input  wire logic                                            cs_n,
  input  wire logic                                            rd_n,
  input  wire logic                                            wr_n,
  input  wire logic [rtc_pkg::AW-1:0]                          addr,
  input  wire logic [rtc_pkg::DW-1:0]                          data_in,
  output logic      [rtc_pkg::DW-1:0]                          data_out,
  output logic                                                 data_oe,
  input  wire logic [rtc_pkg::NUM_FIELDS-1:0][rtc_pkg::DW-1:0] counter_value,
  input  wire logic [rtc_pkg::NUM_TICKS-1:0]                   tick_event,
  input  wire logic                                            div_tick,
  input  wire logic                                            osc_tick,
  output logic                                                 hundredths_clock_en,
  output logic      [rtc_pkg::DW-1:0]                          command,
  output logic                                                 irq
);
  localparam int BUSW = 3 + rtc_pkg::AW + rtc_pkg::DW;

  typedef struct packed {
    logic [rtc_pkg::NUM_FIELDS-1:0][rtc_pkg::DW-1:0] held;
    logic [rtc_pkg::DW-1:0]                          mask;
    logic [rtc_pkg::DW-1:0]                          cmd;
    logic [rtc_pkg::DW-1:0]                          status;
    logic [rtc_pkg::DW-1:0]                          dout;
    logic [rtc_pkg::DW-1:0]                          wdata;
    logic [rtc_pkg::AW-1:0]                          waddr;
    logic                                            irq;
    logic                                            rd_act;
    logic                                            wr_act;
    logic                                            match_q;
  } core_s;
  core_s q;
  core_s next_q;

  logic [BUSW-1:0]                   bus_raw;
  logic [BUSW-1:0]                   bus_f;
  logic                              cs_f;
  logic                              rd_f;
  logic                              wr_f;
  logic [rtc_pkg::AW-1:0]            addr_f;
  logic [rtc_pkg::DW-1:0]            din_f;
  logic                              rd_now;
  logic                              wr_now;
  logic                              rd_start;
  logic                              wr_end;
  logic                              status_rd;
  logic                              hund_rd;
  logic [rtc_pkg::NUM_FIELDS-1:0]    field_ok;
  logic                              match;
  logic                              alarm_evt;
  logic                              gie;
  logic                              periodic_hit;
  logic                              alarm_int;
  logic                              irq_set;

  alarm_mem_if am ();

  assign bus_raw = {cs_n, rd_n, wr_n, addr, data_in};

  // strobes, address and data are all filtered the same way so they stay aligned
  pin_sync #(
    .W         (BUSW),
    .RESET_VAL (rtc_pkg::BUS_IDLE)
  ) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .raw     (bus_raw),
    .filt    (bus_f)
  );

  alarm_ram u_alarm (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .port    (am.mem)
  );

  assign cs_f      = bus_f[BUSW-1];
  assign rd_f      = bus_f[BUSW-2];
  assign wr_f      = bus_f[BUSW-3];
  assign addr_f    = bus_f[rtc_pkg::AW+rtc_pkg::DW-1:rtc_pkg::DW];
  assign din_f     = bus_f[rtc_pkg::DW-1:0];
  assign rd_now    = !cs_f && !rd_f;
  assign wr_now    = !cs_f && !wr_f;
  assign rd_start  = rd_now && !q.rd_act;
  assign wr_end    = !wr_now && q.wr_act;
  assign status_rd = rd_start && (addr_f == rtc_pkg::ADDR_STATUS);
  assign hund_rd   = rd_start && (addr_f == rtc_pkg::ADDR_HUND);

  // one comparator per field; bit 7 of each alarm byte masks the field
  for (genvar i = 0; i < rtc_pkg::NUM_FIELDS; i++) begin : g_field
    if (i == 0) begin : g_hund
      assign field_ok[i] = am.contents[i][rtc_pkg::FIELD_MASK] ?
                           (counter_value[i] == rtc_pkg::ZERO_FIELD) :
                           ({1'b0, am.contents[i][rtc_pkg::DW-2:0]} == counter_value[i]);
    end else begin : g_other
      assign field_ok[i] = am.contents[i][rtc_pkg::FIELD_MASK] ||
                           ({1'b0, am.contents[i][rtc_pkg::DW-2:0]} == counter_value[i]);
    end
  end

  assign match     = &field_ok;
  // one event per match window, not one per cycle while the counters sit on it
  assign alarm_evt = match && !q.match_q;
  assign gie       = q.cmd[rtc_pkg::CMD_GIE];
  // ticks come straight from the free-running chain, so enabling never shifts them
  assign periodic_hit = gie && |(q.mask[rtc_pkg::ST_TICK_HI:rtc_pkg::ST_TICK_LO] & tick_event);
  assign alarm_int    = gie && q.mask[rtc_pkg::ST_ALARM] && alarm_evt;
  assign irq_set      = periodic_hit || alarm_int;

  assign am.we    = wr_end && (q.waddr >= rtc_pkg::ADDR_ALARM_FIRST) &&
                    (q.waddr <= rtc_pkg::ADDR_ALARM_LAST);
  assign am.waddr = q.waddr[rtc_pkg::FIELD_AW-1:0];
  assign am.wdata = q.wdata;
  assign am.raddr = addr_f[rtc_pkg::FIELD_AW-1:0];

  always_comb begin
    next_q         = q;
    next_q.rd_act  = rd_now;
    next_q.wr_act  = wr_now;
    next_q.match_q = match;
    if (wr_now) begin
      next_q.waddr = addr_f;
      next_q.wdata = din_f;
    end
    if (hund_rd) begin
      next_q.held = counter_value;
    end
    // clear first, then sets, so a coincident event survives the read
    if (status_rd) begin
      next_q.status = rtc_pkg::STATUS_RESET;
      next_q.irq    = 1'b0;
    end
    next_q.status[rtc_pkg::ST_TICK_HI:rtc_pkg::ST_TICK_LO] =
      next_q.status[rtc_pkg::ST_TICK_HI:rtc_pkg::ST_TICK_LO] | tick_event;
    if (alarm_int) begin
      next_q.status[rtc_pkg::ST_ALARM] = 1'b1;
    end
    if (irq_set) begin
      next_q.status[rtc_pkg::ST_SUMMARY] = 1'b1;
      next_q.irq                         = 1'b1;
    end
    if (wr_end) begin
      case (q.waddr)
        rtc_pkg::ADDR_STATUS: next_q.mask = q.wdata;
        rtc_pkg::ADDR_CMD:    next_q.cmd  = q.wdata;
        default:              next_q.mask = q.mask;
      endcase
    end
    // read data refreshes every cycle of the strobe, except the status snapshot
    if (rd_now) begin
      if (addr_f == rtc_pkg::ADDR_HUND) begin
        next_q.dout = counter_value[0];
      end else if (addr_f <= rtc_pkg::ADDR_TIME_LAST) begin
        next_q.dout = q.held[addr_f[rtc_pkg::FIELD_AW-1:0]];
      end else if (addr_f <= rtc_pkg::ADDR_ALARM_LAST) begin
        next_q.dout = am.rdata;
      end else if (addr_f == rtc_pkg::ADDR_STATUS) begin
        if (rd_start) begin
          next_q.dout = q.status;
        end
      end else if (addr_f == rtc_pkg::ADDR_CMD) begin
        next_q.dout = q.cmd;
      end else begin
        next_q.dout = rtc_pkg::ZERO_FIELD;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{held:    {rtc_pkg::NUM_FIELDS{rtc_pkg::ZERO_FIELD}},
             mask:    rtc_pkg::MASK_RESET,
             cmd:     rtc_pkg::CMD_RESET,
             status:  rtc_pkg::STATUS_RESET,
             dout:    rtc_pkg::ZERO_FIELD,
             wdata:   rtc_pkg::ZERO_FIELD,
             waddr:   rtc_pkg::ADDR_HUND,
             irq:     1'b0,
             rd_act:  1'b0,
             wr_act:  1'b0,
             match_q: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  assign data_out            = q.dout;
  assign data_oe             = q.rd_act;
  assign command             = q.cmd;
  assign irq                 = q.irq;
  // test mode trades accuracy for a fast hundredths count
  assign hundredths_clock_en = q.cmd[rtc_pkg::CMD_TEST] ? osc_tick : div_tick;

  property p_latch_on_hund;
    @(posedge ref_clk) disable iff (!resetn)
    hund_rd |=> (q.held[7:1] == $past(counter_value[7:1]));
  endproperty
  a_latch_on_hund: assert property (p_latch_on_hund) else $error("held time not captured");

  property p_held_stable;
    @(posedge ref_clk) disable iff (!resetn)
    !hund_rd |=> $stable(q.held[7:1]);
  endproperty
  a_held_stable: assert property (p_held_stable) else $error("held time changed");

  property p_hund_live;
    @(posedge ref_clk) disable iff (!resetn)
    (rd_now && addr_f == rtc_pkg::ADDR_HUND) |=> (data_out == $past(counter_value[0]));
  endproperty
  a_hund_live: assert property (p_hund_live) else $error("hundredths read not live");

  property p_tick_flagged;
    @(posedge ref_clk) disable iff (!resetn)
    (tick_event != '0) |=>
      ((q.status[rtc_pkg::ST_TICK_HI:rtc_pkg::ST_TICK_LO] & $past(tick_event)) == $past(tick_event));
  endproperty
  a_tick_flagged: assert property (p_tick_flagged) else $error("increment not flagged");

  property p_read_clears;
    @(posedge ref_clk) disable iff (!resetn)
    (status_rd && tick_event == '0 && !irq_set) |=> (q.status == rtc_pkg::STATUS_RESET) && !irq;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status read did not clear");

  property p_summary_set;
    @(posedge ref_clk) disable iff (!resetn)
    irq_set |=> q.status[rtc_pkg::ST_SUMMARY] && irq;
  endproperty
  a_summary_set: assert property (p_summary_set) else $error("summary bit or output missing");

  property p_alarm_bits;
    @(posedge ref_clk) disable iff (!resetn)
    alarm_int |=> q.status[rtc_pkg::ST_ALARM] && q.status[rtc_pkg::ST_SUMMARY];
  endproperty
  a_alarm_bits: assert property (p_alarm_bits) else $error("alarm bits not set");

  property p_gate_enable;
    @(posedge ref_clk) disable iff (!resetn)
    !gie |-> !irq_set;
  endproperty
  a_gate_enable: assert property (p_gate_enable) else $error("interrupt without enable");

  property p_sec_only;
    @(posedge ref_clk) disable iff (!resetn)
    (q.mask == rtc_pkg::SEC_ONLY && !tick_event[rtc_pkg::SEC_TICK]) |-> !irq_set;
  endproperty
  a_sec_only: assert property (p_sec_only) else $error("mask 08h raised other source");

  property p_irq_holds;
    @(posedge ref_clk) disable iff (!resetn)
    (irq && !status_rd) |=> irq;
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("interrupt dropped early");

  property p_hund_masked;
    @(posedge ref_clk) disable iff (!resetn)
    (am.contents[0][rtc_pkg::FIELD_MASK] && counter_value[0] != rtc_pkg::ZERO_FIELD) |-> !match;
  endproperty
  a_hund_masked: assert property (p_hund_masked) else $error("masked hundredths not zero");

  property p_test_clock;
    @(posedge ref_clk) disable iff (!resetn)
    q.cmd[rtc_pkg::CMD_TEST] |-> (hundredths_clock_en == osc_tick);
  endproperty
  a_test_clock: assert property (p_test_clock) else $error("test mode source wrong");

  c_status_read:  cover property (@(posedge ref_clk) disable iff (!resetn) irq ##1 status_rd);
  c_alarm_irq:    cover property (@(posedge ref_clk) disable iff (!resetn) alarm_int);
  c_periodic_irq: cover property (@(posedge ref_clk) disable iff (!resetn) periodic_hit);
  c_hund_latch:   cover property (@(posedge ref_clk) disable iff (!resetn) hund_rd);
endmodule
`default_nettype wire

/* dv/cpu_bus_model.sv */
// bus master model: a microprocessor on the 8-bit strobe bus of the clock block
// assumes the device filters its pins on ref_clk and answers within 6 cycles
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model (
  input  wire logic                   ref_clk,
  output logic                        cs_n,
  output logic                        rd_n,
  output logic                        wr_n,
  output logic [rtc_pkg::AW-1:0]      addr,
  output logic [rtc_pkg::DW-1:0]      data_in,
  input  wire logic [rtc_pkg::DW-1:0] data_out,
  input  wire logic                   data_oe
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 5'h00;
    data_in = 8'h00;
  end

  // waits are padded past the pin filter: 5 setup, 8 low, 8 high incl. 5 hold
  task automatic access(input logic wr, input logic [rtc_pkg::AW-1:0] a,
                        input logic [rtc_pkg::DW-1:0] d, output logic [rtc_pkg::DW-1:0] q);
    @(negedge ref_clk);
    addr = a;
    data_in = d;
    repeat (5) @(negedge ref_clk);
    cs_n = 1'b0;
    if (wr) begin
      wr_n = 1'b0;
    end else begin
      rd_n = 1'b0;
    end
    repeat (8) @(negedge ref_clk);
    // an undriven bus must never pass for a value
    q = data_oe ? data_out : 8'hxx;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    repeat (5) @(negedge ref_clk);
    data_in = ~d;
    repeat (3) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* dv/rtc_event_core_bench.sv */
// self-checking bench for the clock latch and interrupt block
// assumes the design checks its own timing; the bench drives at falling edges
`timescale 1ns/1ns
`default_nettype none
module rtc_event_core_bench;
  localparam int TIMEOUT_CYCLES = 10000; // about 68 accesses of 22 cycles plus waits, some five times over
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] cmd;
    logic [2:0] k;
    logic [7:0] status;
    logic       irq;
  } row_s;
  row_s rows [8] = '{'{8'h08, 8'h10, 3'd2, 8'h88, 1'b1}, '{8'h08, 8'h10, 3'd0, 8'h02, 1'b0},
                     '{8'h7e, 8'h00, 3'd5, 8'h40, 1'b0}, '{8'h02, 8'h10, 3'd0, 8'h82, 1'b1},
                     '{8'h04, 8'h10, 3'd1, 8'h84, 1'b1}, '{8'h00, 8'h10, 3'd3, 8'h10, 1'b0},
                     '{8'h20, 8'h10, 3'd4, 8'ha0, 1'b1}, '{8'h40, 8'h10, 3'd5, 8'hc0, 1'b1}};
  logic                                            ref_clk = 1'b0;
  logic                                            resetn = 1'b0;
  logic                                            cs_n;
  logic                                            rd_n;
  logic                                            wr_n;
  logic [rtc_pkg::AW-1:0]                          addr;
  logic [rtc_pkg::DW-1:0]                          data_in;
  logic [rtc_pkg::DW-1:0]                          data_out;
  logic                                            data_oe;
  logic [rtc_pkg::NUM_FIELDS-1:0][rtc_pkg::DW-1:0] counter_value = '0;
  logic [rtc_pkg::NUM_TICKS-1:0]                   tick_event = '0;
  logic                                            div_tick = 1'b0;
  logic                                            osc_tick = 1'b0;
  logic                                            hundredths_clock_en;
  logic [rtc_pkg::DW-1:0]                          command;
  logic                                            irq;
  logic [rtc_pkg::DW-1:0]                          q;
  int                                              mismatches = 0;
  int                                              n_compared = 0;
  int                                              cycles = 0;

  always #2 ref_clk = ~ref_clk;

  cpu_bus_model cpu_bus_model_i (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  rtc_event_core rtc_event_core_i (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .counter_value(counter_value), .tick_event(tick_event),
    .div_tick(div_tick), .osc_tick(osc_tick), .hundredths_clock_en(hundredths_clock_en),
    .command(command), .irq(irq));

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES) begin
      mismatches++;
      close_out();
    end
  end

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] unused;
    cpu_bus_model_i.access(1'b1, a, d, unused);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    cpu_bus_model_i.access(1'b0, a, 8'h00, d);
  endtask

  // one-cycle increment pulse, then room for the flag to settle
  task automatic pulse(input logic [2:0] k);
    @(negedge ref_clk);
    tick_event[k] = 1'b1;
    @(negedge ref_clk);
    tick_event = '0;
    repeat (2) @(negedge ref_clk);
  endtask

  initial begin
    repeat (16) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    chk1("irq after reset", 1'b0, irq);
    chk1("oe after reset", 1'b0, data_oe);
    chk8("command after reset", 8'h00, command);
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      wr(rtc_pkg::ADDR_STATUS, rows[i].mask);
      wr(rtc_pkg::ADDR_CMD, rows[i].cmd);
      rd(rtc_pkg::ADDR_STATUS, q);
      repeat (20) @(negedge ref_clk);
      chk1("irq before tick", 1'b0, irq);
      pulse(rows[i].k);
      chk1("irq on tick", rows[i].irq, irq);
      repeat (20) @(negedge ref_clk);
      chk1("irq held", rows[i].irq, irq);
      rd(rtc_pkg::ADDR_STATUS, q);
      chk8("status", rows[i].status, q);
      chk1("irq released", 1'b0, irq);
      rd(rtc_pkg::ADDR_STATUS, q);
      chk8("status cleared", 8'h00, q);
    end
    // an increment in the very cycle of the clearing read must survive that read
    fork
      rd(rtc_pkg::ADDR_STATUS, q);
      begin
        repeat (10) @(negedge ref_clk);
        tick_event[5] = 1'b1;
        @(negedge ref_clk);
        tick_event = '0;
      end
    join
    chk1("irq kept", 1'b1, irq);
    rd(rtc_pkg::ADDR_STATUS, q);
    chk8("status kept", 8'hc0, q);
    chk1("irq released after kept", 1'b0, irq);
    $display("test periodic rows done");

    rd(rtc_pkg::ADDR_CMD, q);
    chk8("command readback", 8'h10, q);
    for (int m = 0; m < 2; m++) begin
      wr(rtc_pkg::ADDR_CMD, m == 0 ? 8'h20 : 8'h00);
      osc_tick = 1'b1;
      div_tick = 1'b0;
      @(negedge ref_clk);
      chk1("hundredths enable", m == 0, hundredths_clock_en);
      chk8("command port", m == 0 ? 8'h20 : 8'h00, command);
    end
    wr(5'h12, 8'h5a);
    rd(5'h12, q);
    chk8("unmapped read", 8'h00, q);
    $display("test command done");

    counter_value[0] = 8'h12;
    counter_value[3] = 8'h34;
    fork
      rd(rtc_pkg::ADDR_HUND, q);
      begin
        repeat (12) @(negedge ref_clk);
        counter_value[0] = 8'h13;
      end
    join
    chk8("hundredths live", 8'h13, q);
    counter_value[3] = 8'h35;
    wr(5'h03, 8'haa);
    rd(5'h03, q);
    chk8("held seconds", 8'h34, q);
    rd(rtc_pkg::ADDR_HUND, q);
    rd(5'h03, q);
    chk8("reloaded seconds", 8'h35, q);
    $display("test latch done");

    // only seconds compared; hundredths masked so it needs a zero count
    counter_value[0] = 8'h07;
    counter_value[1] = 8'h09;
    for (int f = 0; f < 8; f++) begin
      wr(5'(8 + f), f == 3 ? 8'h15 : 8'h80);
    end
    rd(5'h0b, q);
    chk8("alarm byte", 8'h15, q);
    wr(rtc_pkg::ADDR_STATUS, 8'h01);
    wr(rtc_pkg::ADDR_CMD, 8'h00);
    rd(rtc_pkg::ADDR_STATUS, q);
    counter_value[3] = 8'h15;
    counter_value[0] = 8'h00;
    repeat (4) @(negedge ref_clk);
    chk1("alarm without enable", 1'b0, irq);
    rd(rtc_pkg::ADDR_STATUS, q);
    chk8("status without enable", 8'h00, q);
    counter_value[0] = 8'h07;
    wr(rtc_pkg::ADDR_CMD, 8'h10);
    rd(rtc_pkg::ADDR_STATUS, q);
    repeat (4) @(negedge ref_clk);
    chk1("alarm mid second", 1'b0, irq);
    counter_value[0] = 8'h00;
    repeat (3) @(negedge ref_clk);
    chk1("alarm match", 1'b1, irq);
    rd(rtc_pkg::ADDR_STATUS, q);
    chk8("alarm status", 8'h81, q);
    chk1("alarm released", 1'b0, irq);
    $display("test alarm done");
    close_out();
  end
endmodule
`default_nettype wire
